// ---- hdl/cpu8_adder.sv ----
// 8-bit adder and subtractor producing overflow, half-carry and carry
`default_nettype none
module cpu8_adder (
  // Operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  // Result and flags
  output logic      [7:0] res,
  output logic            ovf,
  output logic            half,
  output logic            cout
);
  logic [7:0] b_eff;
  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    b_eff = sub ? ~b : b;
    sum   = {1'b0, a} + {1'b0, b_eff} + {8'h00, sub ^ cin};
    low   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub ^ cin};
    res   = sum[7:0];
    cout  = sub ? ~sum[8] : sum[8];
    half  = low[4];
    ovf   = (a[7] == b_eff[7]) && (sum[7] != a[7]);
  end
endmodule : cpu8_adder
`default_nettype wire

// ---- hdl/cpu8_regs.sv ----
// Programmer-visible register set, flag logic and AXI4-Lite view
// Contract
// - Accumulator feeds the ALU, takes results, unchanged by reset
// - Reset forces upper index byte to zero, lower byte kept
// - Upper and lower index bytes form one 16-bit pointer
// - Lower index byte clears, counts, complements, negates, shifts, rotates
// - Reset loads the stack pointer with 0x00FF
// - 16-bit stack pointer addresses next free stack location
// - Stack adjust adds a signed 8-bit immediate to the stack pointer
// - Stack low reload changes only the stack pointer low byte
// - Program counter increments on every fetched byte
// - Jumps and interrupts load a target address, branches add a signed offset
// - Reset loads program counter from vector at top of memory
// - Condition code bits 6 and 5 always read one
// - Overflow flag in bit 7 set on two's complement overflow
// - Half carry in bit 4 from bit 3 carry on adds
// - Decimal adjust corrects a prior add using half carry and carry
// - Mask bit 3 set blocks maskable interrupts
// - Mask set on interrupt after pushes, before handler runs
// - No interrupt at the boundary after a mask clear
// - Negative flag in bit 2 follows result MSB, loads included
// - Zero flag in bit 1 set on all-zero result or load
// - Signed branch conditions use the overflow flag
// - Carry flag bit 0 on add carry out or subtract borrow
`default_nettype none
module cpu8_regs (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Register bus
  input  wire cpu8_pkg::axi_req_t axi_req,
  output var cpu8_pkg::axi_rsp_t axi_rsp,
  // Operation command from the sequencer
  input  wire cpu8_pkg::cmd_t    cmd,
  output logic                   cmd_ready,
  // Interrupt handshake
  input  wire logic              irq_req,
  input  wire logic              insn_boundary,
  output logic                   irq_take,
  output logic                   branch_taken,
  // Memory read for the reset vector
  output var cpu8_pkg::mem_req_t mem_req,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              mem_rvalid,
  // Register views
  output logic [7:0]             acc,
  output logic [15:0]            index_ptr,
  output logic [15:0]            stack_ptr,
  output logic [15:0]            prog_counter,
  output logic [7:0]             cond_code_reg
);
  import cpu8_pkg::*;

  typedef enum logic [1:0] {S_VEC_HI, S_VEC_LO, S_RUN} state_t;

  state_t      state_r;
  logic [7:0]  acc_r;
  logic [7:0]  idx_hi_r;
  logic [7:0]  idx_lo_r;
  logic [15:0] sp_r;
  logic [15:0] pc_r;
  logic        v_r, h_r, i_r, n_r, z_r, c_r;
  logic        shadow_r;
  logic        irq_take_r;
  logic        br_taken_r;
  logic        mem_rd_r;
  logic [15:0] mem_addr_r;

  // AXI slave state
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // Combinational operation results
  logic [7:0]  a_in, b_in, alu_res;
  logic        alu_cin, alu_sub, alu_v, alu_h, alu_c;
  logic        run_op, wr_fire;
  logic [7:0]  x_res, daa_corr;
  logic        x_c, x_v, daa_c, br_ok;
  logic [7:0]  ccr_now;

  assign run_op  = cmd.valid && (state_r == S_RUN);
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign ccr_now = {v_r, 1'b1, 1'b1, h_r, i_r, n_r, z_r, c_r};

  // ALU operand selection
  always_comb begin
    a_in    = acc_r;
    b_in    = cmd.operand;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    unique case (cmd.op)
      OP_ADC:   alu_cin = c_r;
      OP_SUB:   alu_sub = 1'b1;
      OP_SBC: begin
        alu_sub = 1'b1;
        alu_cin = c_r;
      end
      OP_INCX: begin
        a_in = idx_lo_r;
        b_in = 8'h01;
      end
      OP_DECX: begin
        a_in    = idx_lo_r;
        b_in    = 8'h01;
        alu_sub = 1'b1;
      end
      OP_NEGX: begin
        a_in    = 8'h00;
        b_in    = idx_lo_r;
        alu_sub = 1'b1;
      end
      decimal_adjust_op: b_in = daa_corr;
      default: ;
    endcase
  end

  cpu8_adder u_adder (
    .a    (a_in),
    .b    (b_in),
    .cin  (alu_cin),
    .sub  (alu_sub),
    .res  (alu_res),
    .ovf  (alu_v),
    .half (alu_h),
    .cout (alu_c)
  );

  // Decimal correction from half carry and carry
  always_comb begin
    daa_c    = c_r || (acc_r > BCD_LIMIT);
    daa_corr = {daa_c ? BCD_CORR : 4'h0,
                (h_r || (acc_r[3:0] > BCD_DIGIT)) ? BCD_CORR : 4'h0};
  end

  // Lower index byte data operations
  always_comb begin
    x_res = idx_lo_r;
    x_c   = c_r;
    x_v   = 1'b0;
    unique case (cmd.op)
      OP_CLRX: x_res = 8'h00;
      OP_INCX, OP_DECX: begin
        x_res = alu_res;
        x_v   = alu_v;
      end
      OP_NEGX: begin
        x_res = alu_res;
        x_v   = alu_v;
        x_c   = alu_c;
      end
      OP_COMX: begin
        x_res = ~idx_lo_r;
        x_c   = 1'b1;
      end
      OP_LSLX, OP_ROLX: begin
        x_res = {idx_lo_r[6:0], (cmd.op == OP_ROLX) ? c_r : 1'b0};
        x_c   = idx_lo_r[7];
        x_v   = idx_lo_r[6] ^ idx_lo_r[7];
      end
      OP_LSRX, OP_RORX: begin
        x_res = {(cmd.op == OP_RORX) ? c_r : 1'b0, idx_lo_r[7:1]};
        x_c   = idx_lo_r[0];
        x_v   = x_res[7] ^ idx_lo_r[0];
      end
      default: ;
    endcase
  end

  // Branch condition
  always_comb begin
    br_ok = 1'b1;
    unique case (cmd.cond)
      BR_ALWAYS:               br_ok = 1'b1;
      BR_EQUAL:                br_ok = z_r;
      BR_NOT_EQUAL:            br_ok = !z_r;
      branch_greater_op:       br_ok = !(z_r || (n_r ^ v_r));
      branch_greater_equal_op: br_ok = !(n_r ^ v_r);
      branch_less_equal_op:    br_ok = z_r || (n_r ^ v_r);
      branch_less_op:          br_ok = n_r ^ v_r;
      default:                 br_ok = 1'b1;
    endcase
  end

  // Reset vector fetch sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= S_VEC_HI;
      mem_rd_r   <= 1'b0;
      mem_addr_r <= VEC_HI_ADDR;
    end else begin
      unique case (state_r)
        S_VEC_HI: begin
          mem_rd_r   <= !mem_rvalid;
          mem_addr_r <= mem_rvalid ? VEC_LO_ADDR : VEC_HI_ADDR;
          if (mem_rvalid && mem_rd_r) begin
            state_r <= S_VEC_LO;
          end
        end
        S_VEC_LO: begin
          mem_rd_r <= !mem_rvalid;
          if (mem_rvalid && mem_rd_r) begin
            state_r <= S_RUN;
          end
        end
        S_RUN: mem_rd_r <= 1'b0;
      endcase
    end
  end

  // Program counter
  always_ff @(posedge aclk) begin
    if (state_r == S_VEC_HI && mem_rd_r && mem_rvalid) begin
      pc_r[15:8] <= mem_rdata;
    end else if (state_r == S_VEC_LO && mem_rd_r && mem_rvalid) begin
      pc_r[7:0] <= mem_rdata;
    end else if (run_op && cmd.op == OP_FETCH) begin
      pc_r <= pc_r + 16'h0001;
    end else if (run_op && (cmd.op == OP_JUMP || cmd.op == OP_IRQ_ENTRY)) begin
      pc_r <= cmd.word;
    end else if (run_op && cmd.op == OP_BRANCH && br_ok) begin
      pc_r <= pc_r + {{8{cmd.operand[7]}}, cmd.operand};
    end else if (wr_fire && aw_addr_r == ADDR_PROG) begin
      pc_r[7:0]  <= w_strb_r[0] ? w_data_r[7:0] : pc_r[7:0];
      pc_r[15:8] <= w_strb_r[1] ? w_data_r[15:8] : pc_r[15:8];
    end
  end

  // Accumulator, no reset
  always_ff @(posedge aclk) begin
    if (run_op) begin
      unique case (cmd.op)
        OP_LOAD_A:                          acc_r <= cmd.operand;
        OP_ADD, OP_ADC, OP_SUB, OP_SBC:     acc_r <= alu_res;
        decimal_adjust_op:                  acc_r <= alu_res;
        OP_TXA:                             acc_r <= idx_lo_r;
        default: ;
      endcase
    end else if (wr_fire && aw_addr_r == ADDR_ACC && w_strb_r[0]) begin
      acc_r <= w_data_r[7:0];
    end
  end

  // Index pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_hi_r <= INDEX_HI_RST;
    end else if (run_op && cmd.op == OP_LOAD_HX) begin
      {idx_hi_r, idx_lo_r} <= cmd.word;
    end else if (run_op && cmd.op == OP_INC_HX) begin
      {idx_hi_r, idx_lo_r} <= {idx_hi_r, idx_lo_r} + 16'h0001;
    end else if (run_op && cmd.op == OP_TAX) begin
      idx_lo_r <= acc_r;
    end else if (run_op) begin
      idx_lo_r <= x_res;
    end else if (wr_fire && aw_addr_r == ADDR_INDEX) begin
      idx_lo_r <= w_strb_r[0] ? w_data_r[7:0] : idx_lo_r;
      idx_hi_r <= w_strb_r[1] ? w_data_r[15:8] : idx_hi_r;
    end
  end

  // Stack pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_r <= STACK_RST;
    end else if (run_op && cmd.op == stack_adjust_op) begin
      sp_r <= sp_r + {{8{cmd.operand[7]}}, cmd.operand};
    end else if (run_op && cmd.op == stack_low_reload_op) begin
      sp_r[7:0] <= STACK_LO_RLD;
    end else if (run_op && cmd.op == OP_PUSH) begin
      sp_r <= sp_r - 16'h0001;
    end else if (run_op && cmd.op == OP_PULL) begin
      sp_r <= sp_r + 16'h0001;
    end else if (wr_fire && aw_addr_r == ADDR_STACK) begin
      sp_r[7:0]  <= w_strb_r[0] ? w_data_r[7:0] : sp_r[7:0];
      sp_r[15:8] <= w_strb_r[1] ? w_data_r[15:8] : sp_r[15:8];
    end
  end

  // Arithmetic flags; unlisted operations leave them alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {v_r, h_r, n_r, z_r, c_r} <= 5'h00;
    end else if (run_op) begin
      unique case (cmd.op)
        OP_LOAD_A, OP_STORE_A: begin
          v_r <= 1'b0;
          n_r <= (cmd.op == OP_LOAD_A) ? cmd.operand[7] : acc_r[7];
          z_r <= (cmd.op == OP_LOAD_A) ? (cmd.operand == 8'h00)
                                       : (acc_r == 8'h00);
        end
        OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
          v_r <= alu_v;
          c_r <= alu_c;
          n_r <= alu_res[7];
          z_r <= (alu_res == 8'h00);
          if (!alu_sub) begin
            h_r <= alu_h;
          end
        end
        OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX,
        OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX: begin
          v_r <= x_v;
          c_r <= x_c;
          n_r <= x_res[7];
          z_r <= (x_res == 8'h00);
        end
        decimal_adjust_op: begin
          c_r <= daa_c;
          n_r <= alu_res[7];
          z_r <= (alu_res == 8'h00);
        end
        OP_LOAD_HX: begin
          v_r <= 1'b0;
          n_r <= cmd.word[15];
          z_r <= (cmd.word == 16'h0000);
        end
        default: ;
      endcase
    end else if (wr_fire && aw_addr_r == ADDR_CCR && w_strb_r[0]) begin
      v_r <= w_data_r[CC_V];
      h_r <= w_data_r[CC_H];
      n_r <= w_data_r[CC_N];
      z_r <= w_data_r[CC_Z];
      c_r <= w_data_r[CC_C];
    end
  end

  // Interrupt mask, recognition shadow and grant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i_r        <= 1'b1;
      shadow_r   <= 1'b0;
      irq_take_r <= 1'b0;
    end else begin
      irq_take_r <= insn_boundary && irq_req && !i_r && !shadow_r;
      if (run_op && cmd.op == mask_clear_op) begin
        i_r      <= 1'b0;
        shadow_r <= 1'b1;
      end else begin
        if (insn_boundary) begin
          shadow_r <= 1'b0;
        end
        if (run_op && (cmd.op == OP_IRQ_ENTRY || cmd.op == OP_MASK_SET)) begin
          i_r <= 1'b1;
        end else if (wr_fire && aw_addr_r == ADDR_CCR && w_strb_r[0]) begin
          i_r <= w_data_r[CC_I];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      br_taken_r <= 1'b0;
    end else begin
      br_taken_r <= run_op && cmd.op == OP_BRANCH && br_ok;
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (axi_req.awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        w_data_r <= axi_req.wdata;
        w_strb_r <= axi_req.wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (aw_addr_r <= ADDR_CCR && aw_addr_r[1:0] == 2'b00)
                    ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && axi_req.bready) begin
        bvalid_r  <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rvalid_r) begin
      rvalid_r <= !axi_req.rready;
    end else if (axi_req.arvalid) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      unique case (axi_req.araddr)
        ADDR_ACC:    rdata_r <= {24'h000000, acc_r};
        ADDR_INDEX:  rdata_r <= {16'h0000, idx_hi_r, idx_lo_r};
        ADDR_STACK:  rdata_r <= {16'h0000, sp_r};
        ADDR_PROG:   rdata_r <= {16'h0000, pc_r};
        ADDR_CCR:    rdata_r <= {24'h000000, ccr_now};
        ADDR_STATUS: rdata_r <= {29'h00000000, shadow_r, state_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end
  end

  // Port views, all from flops
  assign axi_rsp.awready = !aw_hold_r;
  assign axi_rsp.wready  = !w_hold_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.arready = !rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;
  assign mem_req.rd      = mem_rd_r;
  assign mem_req.addr    = mem_addr_r;
  assign cmd_ready       = (state_r == S_RUN);
  assign irq_take        = irq_take_r;
  assign branch_taken    = br_taken_r;
  assign acc             = acc_r;
  assign index_ptr       = {idx_hi_r, idx_lo_r};
  assign stack_ptr       = sp_r;
  assign prog_counter    = pc_r;
  assign cond_code_reg   = ccr_now;

endmodule : cpu8_regs
`default_nettype wire

// ---- shared/cpu8_pkg.sv ----
// Shared constants, types and register map of the 8-bit register set
`default_nettype none
package cpu8_pkg;

  // Register map, byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_ACC    = 8'h00;
  localparam logic [7:0] ADDR_INDEX  = 8'h04;
  localparam logic [7:0] ADDR_STACK  = 8'h08;
  localparam logic [7:0] ADDR_PROG   = 8'h0c;
  localparam logic [7:0] ADDR_CCR    = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Reset values and fixed addresses
  localparam logic [7:0]  INDEX_HI_RST = 8'h00;
  localparam logic [15:0] STACK_RST    = 16'h00ff;
  localparam logic [7:0]  STACK_LO_RLD = 8'hff;
  localparam logic [15:0] VEC_HI_ADDR  = 16'hfffe;
  localparam logic [15:0] VEC_LO_ADDR  = 16'hffff;

  // Condition code bit positions
  localparam int CC_V   = 7;
  localparam int CC_ONE6 = 6;
  localparam int CC_ONE5 = 5;
  localparam int CC_H   = 4;
  localparam int CC_I   = 3;
  localparam int CC_N   = 2;
  localparam int CC_Z   = 1;
  localparam int CC_C   = 0;

  // Decimal adjust constants
  localparam logic [7:0] BCD_LIMIT  = 8'h99;
  localparam logic [3:0] BCD_DIGIT  = 4'h9;
  localparam logic [3:0] BCD_CORR   = 4'h6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_A, OP_STORE_A, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
    OP_TAX, OP_TXA, OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX,
    OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX, decimal_adjust_op,
    stack_adjust_op, stack_low_reload_op, OP_PUSH, OP_PULL,
    OP_LOAD_HX, OP_INC_HX, OP_FETCH, OP_JUMP, OP_BRANCH,
    mask_clear_op, OP_MASK_SET, OP_IRQ_ENTRY
  } op_t;

  typedef enum logic [2:0] {
    BR_ALWAYS, BR_EQUAL, BR_NOT_EQUAL, branch_greater_op,
    branch_greater_equal_op, branch_less_equal_op, branch_less_op
  } br_cond_t;

  typedef struct packed {
    logic       valid;
    op_t        op;
    br_cond_t   cond;
    logic [7:0] operand;
    logic [15:0] word;
  } cmd_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } mem_req_t;

endpackage : cpu8_pkg
`default_nettype wire

// ---- verif/cpu8_regs_bench.sv ----
// Self-checking bench for the register set
`default_nettype none
module cpu8_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cpu8_pkg::*;
  localparam logic [15:0] VEC = 16'hc35a;
  logic aclk = 1'b0, aresetn = 1'b0, irq_req = 1'b0, insn_boundary = 1'b0;
  axi_req_t    req = '0;
  axi_rsp_t    rsp;
  cmd_t        cmd = '0;
  mem_req_t    mreq;
  logic        cmd_ready, irq_take, mvalid, s;
  logic [7:0]  mdata, a, b, c;
  logic [15:0] e;
  logic [31:0] d;
  logic [1:0]  r;
  logic [16:0] hand [5] = '{17'h07f01, 17'h0ff01, 17'h00f01, 17'h10001, 17'h18001};
  int          error_cnt = 0, comparisons = 0, seed = 95;

  cpu8_regs cpu8_regs_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .cmd(cmd), .cmd_ready(cmd_ready), .irq_req(irq_req), .insn_boundary(insn_boundary),
    .irq_take(irq_take), .branch_taken(), .mem_req(mreq), .mem_rdata(mdata),
    .mem_rvalid(mvalid), .acc(), .index_ptr(), .stack_ptr(), .prog_counter(),
    .cond_code_reg());
  vec_mem_model #(.VEC(VEC)) mem_inst (.aclk(aclk), .aresetn(aresetn), .mem_req(mreq),
    .mem_rdata(mdata), .mem_rvalid(mvalid));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      $display("BAD %s expected %h seen %h", n, x, g);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    {req.awvalid, req.awaddr, req.wvalid, req.wdata} <= {1'b1, ad, 1'b1, v};
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    {req.arvalid, req.araddr} <= {1'b1, ad};
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    {d, r} = {rsp.rdata, rsp.rresp};
  endtask : rd

  task automatic rchk(input string n, input logic [7:0] ad, input logic [31:0] x);
    rd(ad);
    chk(n, x, d);
  endtask : rchk

  task automatic op(input op_t o, input logic [7:0] v, input logic [15:0] w);
    {cmd.valid, cmd.op, cmd.operand, cmd.word} <= {1'b1, o, v, w};
    @(posedge aclk);
    cmd.valid <= 1'b0;
    @(posedge aclk);
  endtask : op

  task automatic bnd(input logic x);
    insn_boundary <= 1'b1;
    @(posedge aclk);
    insn_boundary <= 1'b0;
    @(negedge aclk);
    chk("irq_take", x, irq_take);
    @(posedge aclk);
  endtask : bnd

  task automatic ready_wait();
    do @(posedge aclk);
    while (cmd_ready !== 1'b1);
  endtask : ready_wait

  function automatic logic [15:0] alu(input logic [7:0] x, y, input logic sb, input logic [7:0] f0);
    logic [8:0] t;
    logic [7:0] f;
    t = sb ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    f = f0 | 8'h60;
    f[7] = (sb ? x[7] != y[7] : x[7] == y[7]) && t[7] != x[7];
    if (!sb) f[4] = ({1'b0, x[3:0]} + y[3:0]) > 5'h0f;
    f[2] = t[7];
    f[1] = t[7:0] == 8'h00;
    f[0] = t[8];
    return {t[7:0], f};
  endfunction : alu

  function automatic logic [7:0] xop(input op_t o, input logic [7:0] x, input logic ci);
    case (o)
      OP_CLRX: return 8'h00;
      OP_INCX: return x + 8'h01;
      OP_DECX: return x - 8'h01;
      OP_COMX: return ~x;
      OP_NEGX: return 8'h00 - x;
      OP_LSLX: return {x[6:0], 1'b0};
      OP_LSRX: return {1'b0, x[7:1]};
      OP_ROLX: return {x[6:0], ci};
      default: return {ci, x[7:1]};
    endcase
  endfunction : xop

  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    {req.bready, req.rready, req.wstrb} = 6'h3f;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    ready_wait();
    rchk("stack", ADDR_STACK, 32'h00ff);
    rchk("pc", ADDR_PROG, VEC);
    rchk("ccr", ADDR_CCR, 32'h68);
    rd(8'h18);
    chk("unmapped", RESP_SLVERR, r);
    wr(ADDR_STATUS, 32'h0);
    chk("status write", RESP_SLVERR, r);
    op(OP_LOAD_A, 8'h80, 16'h0);
    op(OP_LOAD_A, 8'h00, 16'h0);
    for (int i = 0; i < 45; i++) begin
      {s, a, b} = i < 5 ? hand[i] : 17'($random(seed));
      c = 8'($random(seed));
      wr(ADDR_ACC, {24'h0, a});
      wr(ADDR_CCR, {24'h0, c});
      op(s ? OP_SUB : OP_ADD, b, 16'h0);
      e = alu(a, b, s, c);
      rchk("acc", ADDR_ACC, e[15:8]);
      rchk("ccr", ADDR_CCR, e[7:0]);
    end
    for (int k = int'(OP_CLRX); k <= int'(OP_RORX); k++) begin
      {a, c} = 16'($random(seed));
      wr(ADDR_INDEX, {16'h0, 8'h5c, a});
      wr(ADDR_CCR, {24'h0, c});
      op(op_t'(k), 8'h0, 16'h0);
      rchk("index", ADDR_INDEX, {16'h0, 8'h5c, xop(op_t'(k), a, c[0])});
    end
    wr(ADDR_STACK, 32'h1234);
    op(stack_adjust_op, 8'h80, 16'h0);
    rchk("adjust", ADDR_STACK, 32'h11b4);
    op(stack_low_reload_op, 8'h0, 16'h0);
    op(OP_PUSH, 8'h0, 16'h0);
    rchk("reload", ADDR_STACK, 32'h11fe);
    op(OP_JUMP, 8'h0, 16'h7ffe);
    op(OP_FETCH, 8'h0, 16'h0);
    op(OP_FETCH, 8'h0, 16'h0);
    rchk("pc", ADDR_PROG, 32'h8000);
    irq_req <= 1'b1;
    wr(ADDR_CCR, 32'h08);
    bnd(1'b0);
    {cmd.valid, cmd.op} <= {1'b1, mask_clear_op};
    @(posedge aclk);
    cmd.valid <= 1'b0;
    bnd(1'b0);
    bnd(1'b1);
    irq_req <= 1'b0;
    op(OP_IRQ_ENTRY, 8'h0, 16'h4000);
    rchk("entry", ADDR_PROG, 32'h4000);
    wr(ADDR_CCR, 32'h04);
    cmd.cond <= branch_less_op;
    op(OP_BRANCH, 8'h10, 16'h0);
    cmd.cond <= branch_greater_equal_op;
    op(OP_BRANCH, 8'h10, 16'h0);
    rchk("branch", ADDR_PROG, 32'h4010);
    wr(ADDR_ACC, 32'h5a);
    wr(ADDR_INDEX, 32'h12a5);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ready_wait();
    rchk("acc kept", ADDR_ACC, 32'h5a);
    rchk("index", ADDR_INDEX, 32'h00a5);
    end_sim();
  end
endmodule : cpu8_regs_bench
`default_nettype wire

// ---- verif/cpu8_regs_props.sv ----
// Concurrent checks on the register set ports
`default_nettype none
module cpu8_regs_props
  import cpu8_pkg::*;
(
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Commands and interrupt handshake
  input wire cpu8_pkg::cmd_t       cmd,
  input wire logic                 cmd_ready,
  input wire logic                 irq_req,
  input wire logic                 insn_boundary,
  input wire logic                 irq_take,
  // Vector fetch
  input wire cpu8_pkg::mem_req_t   mem_req,
  input wire logic [7:0]           mem_rdata,
  input wire logic                 mem_rvalid,
  // Register views
  input wire logic [7:0]           acc,
  input wire logic [15:0]          index_ptr,
  input wire logic [15:0]          stack_ptr,
  input wire logic [15:0]          prog_counter,
  input wire logic [7:0]           cond_code_reg
);
  import cpu8_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic        go;
  logic        hc;
  logic [15:0] sext;
  assign go = cmd.valid && cmd_ready;
  assign hc = ({1'b0, acc[3:0]} + {1'b0, cmd.operand[3:0]}) > 5'h0f;
  assign sext = {{8{cmd.operand[7]}}, cmd.operand};
  ccr_ones_a: assert property (
    cond_code_reg[6:5] == 2'b11) else $error("ccr bits 6 and 5 not one");
  reset_vals_a: assert property (
    $rose(aresetn) |-> stack_ptr == STACK_RST && index_ptr[15:8] == INDEX_HI_RST)
    else $error("pointer reset values wrong");
  vec_first_a: assert property (
    $rose(aresetn) |=> mem_req.rd && mem_req.addr == VEC_HI_ADDR)
    else $error("vector fetch did not start at high byte");
  vec_load_a: assert property (
    mem_req.rd && mem_rvalid && mem_req.addr == VEC_LO_ADDR
    |=> cmd_ready && prog_counter[7:0] == $past(mem_rdata)) else $error("vector low byte lost");
  sp_adjust_a: assert property (
    go && cmd.op == stack_adjust_op |=> stack_ptr == $past(stack_ptr) + $past(sext))
    else $error("stack adjust sum wrong");
  sp_reload_a: assert property (
    go && cmd.op == stack_low_reload_op |=> stack_ptr[7:0] == STACK_LO_RLD
    && (stack_ptr & 16'hff00) == ($past(stack_ptr) & 16'hff00)) else $error("reload wrong");
  pc_fetch_a: assert property (
    go && cmd.op == OP_FETCH |=> prog_counter == $past(prog_counter) + 16'h0001)
    else $error("fetch did not step pc");
  irq_entry_a: assert property (
    go && cmd.op == OP_IRQ_ENTRY |=> cond_code_reg[CC_I] && prog_counter == $past(cmd.word))
    else $error("interrupt entry wrong");
  mask_block_a: assert property (
    insn_boundary && irq_req && cond_code_reg[CC_I] |=> !irq_take)
    else $error("masked interrupt taken");
  shadow_block_a: assert property (
    go && cmd.op == mask_clear_op ##1 insn_boundary |=> !irq_take)
    else $error("interrupt taken right after mask clear");
  half_carry_a: assert property (
    go && cmd.op == OP_ADD |=> cond_code_reg[CC_H] == $past(hc)) else $error("half carry wrong");
  load_flags_a: assert property (
    go && cmd.op == OP_LOAD_A |=> acc == $past(cmd.operand) && cond_code_reg[CC_N] == acc[7]
    && cond_code_reg[CC_Z] == (acc == 8'h00)) else $error("load flags wrong");
endmodule : cpu8_regs_props

bind cpu8_regs cpu8_regs_props props_inst (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
  .cmd_ready(cmd_ready), .irq_req(irq_req), .insn_boundary(insn_boundary),
  .irq_take(irq_take), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
  .acc(acc), .index_ptr(index_ptr), .stack_ptr(stack_ptr), .prog_counter(prog_counter),
  .cond_code_reg(cond_code_reg));
`default_nettype wire

// ---- verif/vec_mem_model.sv ----
// Memory holding the reset vector, answering fast and slow in turn
`default_nettype none
module vec_mem_model
  import cpu8_pkg::*;
#(
  parameter logic [15:0] VEC = 16'h1234
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Read port
  input  wire cpu8_pkg::mem_req_t mem_req,
  output logic [7:0]              mem_rdata,
  output logic                    mem_rvalid
);
  import cpu8_pkg::*;
  logic [1:0] wait_r;
  logic       slow_r;
  always_ff @(posedge aclk) begin
    mem_rvalid <= 1'b0;
    // Data lines do not keep the last byte between answers
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      wait_r <= 2'd0;
      slow_r <= 1'b0;
      mem_rdata <= 8'h00;
    end else if (mem_req.rd && !mem_rvalid) begin
      if (wait_r == {slow_r, slow_r}) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= (mem_req.addr == VEC_LO_ADDR) ? VEC[7:0] : VEC[15:8];
        wait_r <= 2'd0;
        slow_r <= ~slow_r;
      end else begin
        wait_r <= wait_r + 2'd1;
      end
    end
  end
endmodule : vec_mem_model
`default_nettype wire
